// ==== dv/emi_mem_model.sv ====
`timescale 1ns/100ps
module emi_mem (
    // clock
    input wire hclk,
    // memory pins
    input wire [15:0] addr,
    input wire [3:0] sel_n,
    input wire wr_n,
    input wire oe,
    input wire [15:0] dout,
    output wire [15:0] din,
    // captured write
    output reg [15:0] wr_data,
    output reg [15:0] wr_addr
);
    reg [15:0] junk = 16'h0000;
    function automatic [15:0] pat(input [15:0] a);
        pat = a ^ 16'h5a3c;
    endfunction
    // no pull on the bus: unselected it shows a changing pattern
    assign din = (!(&sel_n) && wr_n) ? pat(addr) : junk;
    always @(posedge hclk) begin
        junk <= ~din;
        if (oe && !wr_n && !(&sel_n)) begin
            wr_data <= dout;
            wr_addr <= addr;
        end
    end
endmodule

// ==== dv/emi_monitor.sv ====
`timescale 1ns/100ps
module emi_chk (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // watched pins
    input wire acc_ready,
    input wire [15:0] ext_address_bus,
    input wire ext_address_bus_oe,
    input wire ext_data_bus_oe,
    input wire low_data_ram_select_n,
    input wire peripheral_select_n,
    input wire high_data_ram_select_n,
    input wire program_memory_select_n,
    input wire write_strobe_n,
    input wire reset_pin_n
);
    wire [3:0] sel_n = {program_memory_select_n, high_data_ram_select_n,
        peripheral_select_n, low_data_ram_select_n};
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_lo_range: assert property (
        !low_data_ram_select_n |-> ext_address_bus >= 16'h4100 && ext_address_bus <= 16'h7fff)
        else $error("low select outside its range");
    a_io_range: assert property (
        !peripheral_select_n |-> ext_address_bus[15:8] == 8'h40)
        else $error("peripheral select outside its range");
    a_hi_range: assert property (
        !high_data_ram_select_n |-> ext_address_bus[15])
        else $error("high select below its range");
    a_single_select: assert property ($onehot0(~sel_n))
        else $error("more than one select low");
    a_idle_high: assert property (acc_ready |-> &sel_n && write_strobe_n)
        else $error("select or strobe low while idle");
    a_drive_late: assert property (
        $fell(write_strobe_n) && !$past(ext_data_bus_oe) |-> !ext_data_bus_oe)
        else $error("data driven at start of write");
    a_oe_in_write: assert property ($rose(ext_data_bus_oe) |-> !write_strobe_n)
        else $error("data driven outside a write");
    a_hold_on: assert property ($rose(write_strobe_n) |-> ext_data_bus_oe)
        else $error("write data not held");
    a_hold_bound: assert property (not ((write_strobe_n && ext_data_bus_oe) [*4]))
        else $error("write data held too long");
    a_addr_float: assert property (!reset_pin_n |=> !ext_address_bus_oe)
        else $error("address bus driven in pin reset");
    a_addr_keep: assert property (
        acc_ready && $past(acc_ready) && reset_pin_n && $past(reset_pin_n)
        |-> $stable(ext_address_bus))
        else $error("address moved while idle");
    c_write: cover property ($fell(write_strobe_n));
    c_io: cover property ($fell(peripheral_select_n));
    c_hi: cover property ($fell(high_data_ram_select_n));
    c_lo: cover property ($fell(low_data_ram_select_n));
endmodule

bind emi_top emi_chk u_chk (.hclk, .hresetn, .acc_ready, .ext_address_bus, .ext_address_bus_oe,
    .ext_data_bus_oe, .low_data_ram_select_n, .peripheral_select_n, .high_data_ram_select_n,
    .program_memory_select_n, .write_strobe_n, .reset_pin_n);

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps
`include "emi_map.vh"
module tb_top;
    reg hclk, hresetn, hsel, hwrite, hready, acc_req, acc_x_en, acc_y_en, acc_y_write;
    reg reset_pin_n, ring_osc_select, ring_osc_tick, small_signal_clk;
    reg [7:0] haddr;
    reg [1:0] htrans;
    reg [2:0] hsize;
    reg [31:0] hwdata, r, ws, ctl;
    reg [15:0] acc_x_addr, acc_y_addr, acc_y_wdata, xa, ya, wd, fa, fad;
    reg [3:0] seen, exp_seen;
    reg [2:0] ys;
    reg xe, ye, yw, fd;
    integer seed, failures, comparisons, i, n, en;
    wire hreadyout, hresp, acc_ready, acc_done, ext_address_bus_oe, ext_data_bus_oe;
    wire low_data_ram_select_n, peripheral_select_n, high_data_ram_select_n;
    wire program_memory_select_n, write_strobe_n, clock_out_pin;
    wire [31:0] hrdata;
    wire [15:0] acc_x_rdata, acc_y_rdata, ext_address_bus, ext_data_bus_in, ext_data_bus_out;
    wire [15:0] mem_wd, mem_wa;
    wire [3:0] sel_n = {program_memory_select_n, high_data_ram_select_n,
        peripheral_select_n, low_data_ram_select_n};
    localparam [127:0] BND = 128'h3fff_4000_40ff_4100_7fff_8000_ffff_c123;

    emi_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hrdata, .hresp, .acc_req, .acc_x_en, .acc_x_addr, .acc_y_en, .acc_y_addr,
        .acc_y_write, .acc_y_wdata, .acc_ready, .acc_done, .acc_x_rdata, .acc_y_rdata,
        .ext_address_bus, .ext_address_bus_oe, .ext_data_bus_in, .ext_data_bus_out,
        .ext_data_bus_oe, .low_data_ram_select_n, .peripheral_select_n,
        .high_data_ram_select_n, .program_memory_select_n, .write_strobe_n, .reset_pin_n,
        .ring_osc_select, .ring_osc_tick, .small_signal_clk, .clock_out_pin);
    emi_mem u_mem (.hclk, .addr(ext_address_bus), .sel_n(sel_n), .wr_n(write_strobe_n),
        .oe(ext_data_bus_oe), .dout(ext_data_bus_out), .din(ext_data_bus_in),
        .wr_data(mem_wd), .wr_addr(mem_wa));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) ring_osc_tick <= $random(seed);
    always @(negedge hclk) begin
        if (!(&sel_n)) begin
            if (seen == 4'h0) fad = ext_address_bus;
            seen = seen | ~sel_n;
        end
    end

    task automatic chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        begin
            @(posedge hclk);
            htrans <= 2'h2;
            hwrite <= w;
            haddr <= a;
            @(negedge hclk);
            while (hreadyout !== 1'b1) @(negedge hclk);
            @(posedge hclk);
            htrans <= 2'h0;
            hwdata <= d;
            @(negedge hclk);
            while (hreadyout !== 1'b1) @(negedge hclk);
            r = hrdata;
        end
    endtask
    task automatic acc(input logic [15:0] xa, input logic [15:0] ya, input logic [15:0] wd);
        begin
            @(posedge hclk);
            acc_req <= 1'b1;
            acc_x_en <= xe;
            acc_y_en <= ye;
            acc_y_write <= yw;
            acc_x_addr <= xa;
            acc_y_addr <= ya;
            acc_y_wdata <= wd;
            @(negedge hclk);
            while (acc_ready !== 1'b1) @(negedge hclk);
            @(posedge hclk);
            acc_req <= 1'b0;
            seen = 4'h0;
            n = 0;
            do begin
                @(negedge hclk);
                n = n + 1;
            end while (acc_done !== 1'b1);
        end
    endtask
    function automatic [2:0] yseg(input [15:0] a, input [31:0] c);
        if (a < `EMI_IO_BASE) yseg = 3'h4;
        else if (c[`EMI_CTRL_WPM]) yseg = `EMI_SEG_PM;
        else if (a <= `EMI_IO_LAST) yseg = `EMI_SEG_IO;
        else if (a < `EMI_HI_BASE) yseg = `EMI_SEG_LO;
        else yseg = `EMI_SEG_HI;
    endfunction
    task summarize;
        begin
            if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask

    initial begin
        #200_000;
        failures = failures + 1;
        summarize;
    end
    initial begin
        {hresetn, hwrite, acc_req, acc_x_en, acc_y_en, acc_y_write} = 6'h00;
        {ring_osc_select, ring_osc_tick, small_signal_clk, haddr, htrans} = 13'h0000;
        {hwdata, acc_x_addr, acc_y_addr, acc_y_wdata} = 80'h0;
        {hsel, hready, reset_pin_n, hsize} = 6'h3a;
        seed = 32'h740d_37d2;
        failures = 0;
        comparisons = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, `EMI_REG_WAIT, 32'h0);
        chk(r[15:0], `EMI_WAIT_RST);
        ahb(1'b0, `EMI_REG_CTRL, 32'h0);
        chk(r[15:0], `EMI_CTRL_RST);
        ahb(1'b0, 8'h0c, 32'h0);
        chk(r, 32'h0);
        ahb(1'b1, `EMI_REG_CTRL, 32'h0000_0180);
        repeat (4) @(negedge hclk);
        chk(clock_out_pin, 1'b0);
        ahb(1'b1, `EMI_REG_CTRL, 32'h0000_2000);
        repeat (4) @(negedge hclk);
        chk(clock_out_pin, 1'b1);
        @(posedge hclk);
        reset_pin_n <= 1'b0;
        repeat (2) @(negedge hclk);
        chk(ext_address_bus_oe, 1'b0);
        @(posedge hclk);
        reset_pin_n <= 1'b1;
        for (i = 0; i < 48; i = i + 1) begin
            ws = $random(seed);
            ctl = $random(seed) & 32'h0000_4810;
            ahb(1'b1, `EMI_REG_WAIT, ws);
            ahb(1'b1, `EMI_REG_CTRL, ctl);
            {xe, ye, yw} = $random(seed);
            xa = $random(seed);
            wd = $random(seed);
            ya = i[0] ? BND[i[3:1]*16 +: 16] : $random(seed);
            ys = yseg(ya, ctl);
            fd = ctl[`EMI_CTRL_WPM] & ctl[`EMI_CTRL_XPM];
            fa = fd ? (ya & 16'h7fff) : ya;
            acc(xa, ya, wd);
            en = (xe ? 2 * (ws[15:12] + 1) : 0) + ((ye && ys < 4) ? 2 * (ws[ys*4 +: 4] + 1) : 0);
            exp_seen = (xe ? 4'h8 : 4'h0) | ((ye && ys < 4) ? (4'h1 << ys) : 4'h0);
            if (!ctl[`EMI_CTRL_SELDLY]) chk(n, en + 1);
            chk(seen, exp_seen);
            if (xe && ye && ys < 4 && !fd) chk(fad, xa);
            if (xe && !fd) chk(acc_x_rdata, u_mem.pat(xa));
            if (ye && ys < 4 && !yw) chk(acc_y_rdata, u_mem.pat(fa));
            if (ye && ys < 4 && yw) chk({mem_wd, mem_wa}, {wd, fa});
            repeat ($unsigned($random(seed)) % 4) @(posedge hclk);
        end
        chk(ext_address_bus_oe, 1'b1);
        summarize;
    end
endmodule

// ==== verilog/emi_clkout.v ====
`timescale 1ns/100ps
`include "emi_map.vh"

module emi_clkout (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // control
    input wire [2:0] mode,
    input wire ring_osc_select,
    input wire ring_osc_tick,
    input wire small_signal_clk,
    // stretch requests from the access engine
    input wire stretch_insn,
    input wire stretch_seq,
    // pin
    output reg clock_out_pin
);

    reg free_r;
    reg tick;
    reg stretch;

    always @* begin
        tick = ring_osc_select ? ring_osc_tick : 1'b1;
        stretch = (mode == `EMI_CKM_SEQ) ? stretch_seq : stretch_insn;
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            free_r <= 1'b0;
            clock_out_pin <= 1'b0;
        end else begin
            if (tick) begin
                free_r <= ~free_r;
            end
            case (mode)
                `EMI_CKM_LOW: clock_out_pin <= 1'b0;
                `EMI_CKM_HIGH: clock_out_pin <= 1'b1;
                `EMI_CKM_SEQ, `EMI_CKM_INSN: begin
                    // falls only with the free clock; rise is held off while stretching
                    if (tick && free_r) begin
                        clock_out_pin <= 1'b0;
                    end else if (tick && !free_r && !stretch) begin
                        clock_out_pin <= 1'b1;
                    end
                end
                `EMI_CKM_CORE: begin
                    // a flop copy is the nearest full-rate form while small_signal_clk is high; otherwise ~free_r is copied on each tick, ring source included
                    if (small_signal_clk) begin
                        clock_out_pin <= ~clock_out_pin;
                    end else if (tick) begin
                        clock_out_pin <= ~free_r;
                    end
                end
                default: begin
                    if (tick) begin
                        clock_out_pin <= ~free_r;
                    end
                end
            endcase
        end
    end

endmodule

// ==== verilog/emi_map.vh ====
`ifndef EMI_MAP_VH
`define EMI_MAP_VH

// register byte offsets
`define EMI_REG_WAIT 8'h00
`define EMI_REG_CTRL 8'h04
`define EMI_REG_STAT 8'h08

// wait-state fields, one nibble per segment
`define EMI_WS_LO_LSB 0
`define EMI_WS_IO_LSB 4
`define EMI_WS_HI_LSB 8
`define EMI_WS_PM_LSB 12
`define EMI_WS_W 4

// control register bits
`define EMI_CTRL_SELDLY 4
`define EMI_CTRL_CKM0 7
`define EMI_CTRL_CKM1 8
`define EMI_CTRL_WPM 11
`define EMI_CTRL_CKM2 13
`define EMI_CTRL_XPM 14
`define EMI_CTRL_MASK 16'h6990

// reset values
`define EMI_WAIT_RST 16'hffff
`define EMI_CTRL_RST 16'h0000

// clock-out modes {b13,b8,b7}
`define EMI_CKM_FREE 3'h0
`define EMI_CKM_SEQ 3'h1
`define EMI_CKM_INSN 3'h2
`define EMI_CKM_LOW 3'h3
`define EMI_CKM_HIGH 3'h4
`define EMI_CKM_CORE 3'h5

// data-space segment bounds
`define EMI_IO_BASE 16'h4000
`define EMI_IO_LAST 16'h40ff
`define EMI_LO_BASE 16'h4100
`define EMI_HI_BASE 16'h8000

// one-hot segment index
`define EMI_SEG_LO 0
`define EMI_SEG_IO 1
`define EMI_SEG_HI 2
`define EMI_SEG_PM 3

// address bit folded away in extended program mode
`define EMI_FOLD_BIT 15

// hold after a write, in hclk cycles (one clock-out period)
`define EMI_HOLD_CYC 2'h2

`endif

// ==== verilog/emi_seg_decode.v ====
`timescale 1ns/100ps
`include "emi_map.vh"

module emi_seg_decode #(
    parameter AW = 16
) (
    // request
    input wire [AW-1:0] addr,
    input wire data_space,
    // control
    input wire write_program_mem_en,
    input wire extended_program_mem_en,
    // result
    output reg [3:0] seg,
    output reg [AW-1:0] addr_out
);

    always @* begin
        seg = 4'h0;
        addr_out = addr;
        if (!data_space) begin
            seg[`EMI_SEG_PM] = 1'b1;
        end else if (addr >= `EMI_HI_BASE) begin
            seg[`EMI_SEG_HI] = 1'b1;
        end else if (addr >= `EMI_LO_BASE) begin
            seg[`EMI_SEG_LO] = 1'b1;
        end else if (addr >= `EMI_IO_BASE) begin
            seg[`EMI_SEG_IO] = 1'b1;
        end
        // redirect data-space traffic to program memory for downloads
        if (data_space && write_program_mem_en && (seg != 4'h0)) begin
            seg = 4'h0;
            seg[`EMI_SEG_PM] = 1'b1;
            if (extended_program_mem_en) begin
                addr_out[`EMI_FOLD_BIT] = 1'b0;
            end
        end
    end

endmodule

// ==== verilog/emi_top.v ====
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
`include "emi_map.vh"

// Behaviour
// - one 16-bit address and data bus shared by program and data traffic
// - data access 0x4100..0x7FFF asserts low data RAM select
// - data access 0x4000..0x40FF asserts peripheral select
// - data access at or above 0x8000 asserts high data RAM select
// - program memory access asserts program memory select
// - each segment stretches its cycle by its own 0..15 wait-states
// - external reference routes its bus and asserts only its select
// - write strobe stays low for the whole write cycle
// - write data driven from the middle of the cycle
// - write data held one more clock unless another external access follows
// - X access first then Y, each with its own wait-states
// - zero-wait sequenced access takes one cycle, no hold between them
// - program-write bit turns data selects into program select
// - with extended bit too, address bit 15 forced low
// - address bus keeps last external address during internal accesses
// - reset pin low floats the address bus
// - optional half clock-out delay of select asserting edge
// - control bits 7, 8, 13 choose clock-out mode
// - slow option switches clock-out to ring oscillator ticks, except the core copy while small_signal_clk is high
// - wait-stated clock falls together with free clock
// - clock-out may be constant high, low, or core clock copy
module emi_top #(
    parameter AW = 16,
    parameter DW = 16
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg [31:0] hrdata,
    output reg hresp,
    // core access port
    input wire acc_req,
    input wire acc_x_en,
    input wire [AW-1:0] acc_x_addr,
    input wire acc_y_en,
    input wire [AW-1:0] acc_y_addr,
    input wire acc_y_write,
    input wire [DW-1:0] acc_y_wdata,
    output reg acc_ready,
    output reg acc_done,
    output reg [DW-1:0] acc_x_rdata,
    output reg [DW-1:0] acc_y_rdata,
    // external memory pins
    output reg [AW-1:0] ext_address_bus,
    output reg ext_address_bus_oe,
    input wire [DW-1:0] ext_data_bus_in,
    output reg [DW-1:0] ext_data_bus_out,
    output reg ext_data_bus_oe,
    output reg low_data_ram_select_n,
    output reg peripheral_select_n,
    output reg high_data_ram_select_n,
    output reg program_memory_select_n,
    output reg write_strobe_n,
    // clocking and misc pins
    input wire reset_pin_n,
    input wire ring_osc_select,
    input wire ring_osc_tick,
    input wire small_signal_clk,
    output wire clock_out_pin
);

    localparam S_IDLE = 3'b001;
    localparam S_ACC = 3'b010;
    localparam S_HOLD = 3'b100;

    reg [2:0] state_r;
    reg [15:0] wait_r;
    reg [15:0] ctrl_r;
    reg [7:0] bus_addr_r;
    reg bus_wr_r;
    reg [5:0] cnt_r;
    reg [1:0] hold_r;
    reg y_pend_r;
    reg in_x_r;
    reg cur_wr_r;
    reg [3:0] cur_seg_r;
    reg [3:0] cur_ws_r;
    reg seq_r;
    reg [AW-1:0] y_addr_r;
    reg y_wr_r;
    reg [DW-1:0] y_wdata_r;
    reg y_ext_r;
    reg [3:0] y_seg_r;

    wire [3:0] x_seg;
    wire [AW-1:0] x_addr_dec;
    wire [3:0] y_seg;
    wire [AW-1:0] y_addr_dec;
    wire [3:0] q_seg;
    wire [AW-1:0] q_addr_dec;
    wire stretch_now;

    wire wpm = ctrl_r[`EMI_CTRL_WPM];
    wire xpm = ctrl_r[`EMI_CTRL_XPM];
    wire seldly = ctrl_r[`EMI_CTRL_SELDLY];
    wire [2:0] ck_mode = {ctrl_r[`EMI_CTRL_CKM2], ctrl_r[`EMI_CTRL_CKM1],
                          ctrl_r[`EMI_CTRL_CKM0]};

    // X space is always program memory, Y space is data
    emi_seg_decode #(.AW(AW)) u_dec_x (
        .addr(acc_x_addr),
        .data_space(1'b0),
        .write_program_mem_en(wpm),
        .extended_program_mem_en(xpm),
        .seg(x_seg),
        .addr_out(x_addr_dec)
    );

    emi_seg_decode #(.AW(AW)) u_dec_y (
        .addr(acc_y_addr),
        .data_space(1'b1),
        .write_program_mem_en(wpm),
        .extended_program_mem_en(xpm),
        .seg(y_seg),
        .addr_out(y_addr_dec)
    );

    // queued Y is decoded again when launched, with the control then in force
    emi_seg_decode #(.AW(AW)) u_dec_q (
        .addr(y_addr_r),
        .data_space(1'b1),
        .write_program_mem_en(wpm),
        .extended_program_mem_en(xpm),
        .seg(q_seg),
        .addr_out(q_addr_dec)
    );

    emi_clkout u_cko (
        .hclk(hclk),
        .hresetn(hresetn),
        .mode(ck_mode),
        .ring_osc_select(ring_osc_select),
        .ring_osc_tick(ring_osc_tick),
        .small_signal_clk(small_signal_clk),
        .stretch_insn(stretch_now),
        .stretch_seq(stretch_now & seq_r),
        .clock_out_pin(clock_out_pin)
    );

    // per-segment wait-state lookup
    function [3:0] ws_of;
        input [3:0] seg;
        input [15:0] w;
        begin
            ws_of = 4'h0;
            case (1'b1)
                seg[`EMI_SEG_LO]: ws_of = w[`EMI_WS_LO_LSB +: `EMI_WS_W];
                seg[`EMI_SEG_IO]: ws_of = w[`EMI_WS_IO_LSB +: `EMI_WS_W];
                seg[`EMI_SEG_HI]: ws_of = w[`EMI_WS_HI_LSB +: `EMI_WS_W];
                seg[`EMI_SEG_PM]: ws_of = w[`EMI_WS_PM_LSB +: `EMI_WS_W];
                default: ws_of = 4'h0;
            endcase
        end
    endfunction

    // stretched length in hclk: two per base cycle, two per wait-state
    function [5:0] len_of;
        input [3:0] ws;
        begin
            len_of = {1'b0, ws, 1'b1};
        end
    endfunction

    wire x_ext = acc_x_en & (x_seg != 4'h0);
    wire y_ext = acc_y_en & (y_seg != 4'h0);
    wire take = acc_req & acc_ready;
    assign stretch_now = state_r[1] & (cnt_r > 6'h01);
    wire last_ph = state_r[1] & (cnt_r == 6'h00);
    wire next_rd = take ? ((x_ext & ~y_ext) | (y_ext & ~acc_y_write)) : 1'b0;
    // segment of an access starting now; its strobe covers the whole cycle
    wire [3:0] ld_seg = (state_r[0] & take) ? (x_ext ? x_seg : (y_ext ? y_seg : 4'h0)) :
        ((last_ph & y_pend_r) ? q_seg : 4'h0);
    wire ld_wr = state_r[0] ? (~x_ext & acc_y_write) : y_wr_r;

    // ahb-lite slave, zero wait-state
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_addr_r <= 8'h00;
            bus_wr_r <= 1'b0;
            wait_r <= `EMI_WAIT_RST;
            ctrl_r <= `EMI_CTRL_RST;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            bus_wr_r <= 1'b0;
            if (bus_wr_r) begin
                if (bus_addr_r == `EMI_REG_WAIT) begin
                    wait_r <= hwdata[15:0];
                end else if (bus_addr_r == `EMI_REG_CTRL) begin
                    ctrl_r <= hwdata[15:0] & `EMI_CTRL_MASK;
                end
            end
            if (hsel && htrans[1] && hready) begin
                bus_addr_r <= haddr;
                bus_wr_r <= hwrite;
                case (haddr)
                    `EMI_REG_WAIT: hrdata <= {16'h0000, wait_r};
                    `EMI_REG_CTRL: hrdata <= {16'h0000, ctrl_r};
                    `EMI_REG_STAT: hrdata <= {13'h0000, state_r, ext_address_bus};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // access engine
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= S_IDLE;
            cnt_r <= 6'h00;
            hold_r <= 2'h0;
            y_pend_r <= 1'b0;
            in_x_r <= 1'b0;
            cur_wr_r <= 1'b0;
            cur_seg_r <= 4'h0;
            cur_ws_r <= 4'h0;
            seq_r <= 1'b0;
            y_addr_r <= {AW{1'b0}};
            y_wr_r <= 1'b0;
            y_wdata_r <= {DW{1'b0}};
            y_ext_r <= 1'b0;
            y_seg_r <= 4'h0;
            acc_ready <= 1'b1;
            acc_done <= 1'b0;
            acc_x_rdata <= {DW{1'b0}};
            acc_y_rdata <= {DW{1'b0}};
            ext_address_bus <= {AW{1'b0}};
            ext_address_bus_oe <= 1'b0;
            ext_data_bus_out <= {DW{1'b0}};
            ext_data_bus_oe <= 1'b0;
            low_data_ram_select_n <= 1'b1;
            peripheral_select_n <= 1'b1;
            high_data_ram_select_n <= 1'b1;
            program_memory_select_n <= 1'b1;
            write_strobe_n <= 1'b1;
        end else begin
            acc_done <= 1'b0;
            ext_address_bus_oe <= reset_pin_n;
            case (state_r)
                S_IDLE: begin
                    low_data_ram_select_n <= 1'b1;
                    peripheral_select_n <= 1'b1;
                    high_data_ram_select_n <= 1'b1;
                    program_memory_select_n <= 1'b1;
                    write_strobe_n <= 1'b1;
                    if (take) begin
                        y_pend_r <= y_ext;
                        y_ext_r <= y_ext;
                        y_addr_r <= acc_y_addr;
                        y_wr_r <= acc_y_write;
                        y_wdata_r <= acc_y_wdata;
                        y_seg_r <= y_seg;
                        seq_r <= x_ext & y_ext;
                        if (x_ext) begin
                            // X goes out first, Y waits its turn
                            state_r <= S_ACC;
                            acc_ready <= 1'b0;
                            in_x_r <= 1'b1;
                            cur_wr_r <= 1'b0;
                            cur_seg_r <= x_seg;
                            cur_ws_r <= ws_of(x_seg, wait_r);
                            cnt_r <= len_of(ws_of(x_seg, wait_r));
                            ext_address_bus <= x_addr_dec;
                            ext_data_bus_oe <= 1'b0;
                        end else if (y_ext) begin
                            state_r <= S_ACC;
                            acc_ready <= 1'b0;
                            in_x_r <= 1'b0;
                            y_pend_r <= 1'b0;
                            cur_wr_r <= acc_y_write;
                            cur_seg_r <= y_seg;
                            cur_ws_r <= ws_of(y_seg, wait_r);
                            cnt_r <= len_of(ws_of(y_seg, wait_r));
                            ext_address_bus <= y_addr_dec;
                            ext_data_bus_out <= acc_y_wdata;
                            ext_data_bus_oe <= 1'b0;
                        end else begin
                            // internal only: pins keep the last external address
                            acc_done <= 1'b1;
                        end
                    end
                    if (hold_r != 2'h0) begin
                        hold_r <= hold_r - 2'h1;
                        if (hold_r == 2'h1) begin
                            ext_data_bus_oe <= 1'b0;
                        end
                    end
                    if (take && next_rd) begin
                        // a read right behind a write cuts the hold short
                        hold_r <= 2'h0;
                        ext_data_bus_oe <= 1'b0;
                    end else if (take && (x_ext | y_ext)) begin
                        hold_r <= 2'h0;
                    end
                end
                S_ACC: begin
                    low_data_ram_select_n <= ~cur_seg_r[`EMI_SEG_LO];
                    peripheral_select_n <= ~cur_seg_r[`EMI_SEG_IO];
                    high_data_ram_select_n <= ~cur_seg_r[`EMI_SEG_HI];
                    program_memory_select_n <= ~cur_seg_r[`EMI_SEG_PM];
                    write_strobe_n <= ~cur_wr_r;
                    if (cur_wr_r && (cnt_r <= {2'b00, cur_ws_r} + 6'h01)) begin
                        ext_data_bus_oe <= 1'b1;
                    end
                    cnt_r <= cnt_r - 6'h01;
                    if (last_ph) begin
                        low_data_ram_select_n <= 1'b1;
                        peripheral_select_n <= 1'b1;
                        high_data_ram_select_n <= 1'b1;
                        program_memory_select_n <= 1'b1;
                        write_strobe_n <= 1'b1;
                        if (in_x_r) begin
                            acc_x_rdata <= ext_data_bus_in;
                        end else if (!cur_wr_r) begin
                            acc_y_rdata <= ext_data_bus_in;
                        end
                        if (y_pend_r) begin
                            // sequenced next access: no write hold in between
                            state_r <= S_ACC;
                            y_pend_r <= 1'b0;
                            in_x_r <= 1'b0;
                            cur_wr_r <= y_wr_r;
                            cur_seg_r <= q_seg;
                            cur_ws_r <= ws_of(q_seg, wait_r);
                            cnt_r <= len_of(ws_of(q_seg, wait_r));
                            ext_address_bus <= q_addr_dec;
                            ext_data_bus_out <= y_wdata_r;
                            ext_data_bus_oe <= 1'b0;
                        end else begin
                            acc_done <= 1'b1;
                            acc_ready <= 1'b1;
                            seq_r <= 1'b0;
                            state_r <= S_IDLE;
                            if (cur_wr_r) begin
                                hold_r <= `EMI_HOLD_CYC;
                            end
                        end
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                    acc_ready <= 1'b1;
                end
            endcase
            if (ld_seg != 4'h0) begin
                write_strobe_n <= ~ld_wr;
                if (!seldly) begin
                    {program_memory_select_n, high_data_ram_select_n, peripheral_select_n,
                        low_data_ram_select_n} <= ~ld_seg;
                end
            end
        end
    end

endmodule
